// *** core/ffc_ecc.sv ***
`timescale 1ns/100ps
module ffc_ecc import ffc_pkg::*; (
    // encoder side
    input  wire logic [FFC_DATA_W-1:0] enc_data,
    input  wire logic                  inj_sbit,
    input  wire logic                  inj_dbit,
    output logic      [FFC_CODE_W-1:0] enc_code,
    // decoder side
    input  wire logic [FFC_CODE_W-1:0] dec_code,
    output logic      [FFC_DATA_W-1:0] dec_data,
    output logic                       dec_sbit,
    output logic                       dec_dbit
);

    logic [FFC_CODE_W-1:0] word;
    logic [FFC_CODE_W-1:0] fixed;
    logic [FFC_PAR_N-1:0]  syn;
    logic                  ovr;

    // hamming encode, then overall parity in bit 0; injection flips data bits after coding
    always_comb begin
        word = FFC_CODE_RST;
        for (int i = 0; i < FFC_DATA_W; i++) begin
            word[FFC_DPOS[i]] = enc_data[i];
        end
        for (int k = 0; k < FFC_PAR_N; k++) begin
            for (int p = 1; p < FFC_CODE_W; p++) begin
                if (p[k] && (p != (1 << k))) begin
                    word[1 << k] = word[1 << k] ^ word[p];
                end
            end
        end
        word[0] = ^word[FFC_CODE_W-1:1];
        if (inj_sbit || inj_dbit) begin
            word[FFC_INJ_POS_A] = ~word[FFC_INJ_POS_A];
        end
        if (inj_dbit) begin
            word[FFC_INJ_POS_B] = ~word[FFC_INJ_POS_B];
        end
        enc_code = word;
    end

    // syndrome points at the bad bit; overall parity tells one error from two
    always_comb begin
        syn = '0;
        for (int k = 0; k < FFC_PAR_N; k++) begin
            for (int p = 1; p < FFC_CODE_W; p++) begin
                if (p[k]) begin
                    syn[k] = syn[k] ^ dec_code[p];
                end
            end
        end
        ovr   = ^dec_code;
        fixed = dec_code;
        if (ovr && (syn != '0) && (int'(syn) < FFC_CODE_W)) begin
            fixed[syn] = ~fixed[syn];
        end
        for (int i = 0; i < FFC_DATA_W; i++) begin
            dec_data[i] = fixed[FFC_DPOS[i]];
        end
        dec_sbit = ovr;
        dec_dbit = !ovr && (syn != '0);
    end

endmodule

// *** core/ffc_fifo.sv ***
// Contract
// - programmable empty turns on at assert threshold
// - programmable empty turns off past negate threshold
// - thresholds taken up while held in reset
// - pulse single-error flag on corrected read word
// - raise double-error flag on uncorrectable read
// - reset-busy high while in reset state
// - everything sampled on the one shared clock
// - asynchronous reset always present; synchronous reset a build-time option
// - asynchronous reset clears pointers and outputs immediately
// - synchronous reset clears at next clock edge
// - write when not full stores input word
// - writes ignored while full
// - read when not empty delivers oldest word
// - reads ignored while empty
// - count keeps upper bits when narrowed
// - almost full means one write left
// - programmable full with assert and negate thresholds
// - write acknowledge the cycle after accepted write
// - overflow the cycle after rejected write
// - underflow the cycle after rejected read
// - output valid when a read delivered data
`timescale 1ns/100ps
module ffc_fifo import ffc_pkg::*; #(
    parameter bit SYNC_RST_EN = 1'b1
) (
    // clock and resets
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  srst,
    // write side
    input  wire logic                  wr_req,
    input  wire logic [FFC_DATA_W-1:0] wr_data,
    input  wire logic                  inj_sbit,
    input  wire logic                  inj_dbit,
    output logic                       full,
    output logic                       almost_full,
    output logic                       prog_full,
    output logic                       wr_ack,
    output logic                       overflow,
    // read side
    input  wire logic                  rd_req,
    output logic      [FFC_DATA_W-1:0] rd_data,
    output logic                       rd_valid,
    output logic                       empty,
    output logic                       prog_empty,
    output logic                       underflow,
    output logic                       sbit_err,
    output logic                       dbit_err,
    output logic                       rd_rst_busy,
    output logic      [FFC_DCNT_W-1:0] data_count,
    // thresholds, taken up during reset
    input  wire logic [FFC_CNT_W-1:0]  pf_thr_assert,
    input  wire logic [FFC_CNT_W-1:0]  pf_thr_negate,
    input  wire logic [FFC_CNT_W-1:0]  pe_thr_assert,
    input  wire logic [FFC_CNT_W-1:0]  pe_thr_negate
);

    logic                  srst_act;
    logic                  wr_acc;
    logic                  rd_acc;
    logic [FFC_CODE_W-1:0] enc_code;
    logic [FFC_CODE_W-1:0] mem_code;
    logic [FFC_DATA_W-1:0] dec_data;
    logic                  dec_sbit;
    logic                  dec_dbit;

    // pointer and flag group
    logic [FFC_PTR_W-1:0] wptr_ff, nxt_wptr;
    logic [FFC_PTR_W-1:0] rptr_ff, nxt_rptr;
    logic [FFC_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic                 full_ff, nxt_full;
    logic                 empty_ff, nxt_empty;
    logic                 afull_ff, nxt_afull;
    logic                 pfull_ff, nxt_pfull;
    logic                 pempty_ff, nxt_pempty;
    logic                 busy_ff, nxt_busy;
    logic                 ack_ff, nxt_ack;
    logic                 ovf_ff, nxt_ovf;
    logic                 udf_ff, nxt_udf;
    logic                 rdpend_ff, nxt_rdpend;

    // threshold group
    logic [FFC_CNT_W-1:0] pfa_ff, nxt_pfa;
    logic [FFC_CNT_W-1:0] pfn_ff, nxt_pfn;
    logic [FFC_CNT_W-1:0] pea_ff, nxt_pea;
    logic [FFC_CNT_W-1:0] pen_ff, nxt_pen;

    // read output group
    logic [FFC_DATA_W-1:0] dout_ff, nxt_dout;
    logic                  valid_ff, nxt_valid;
    logic                  sbit_ff, nxt_sbit;
    logic                  dbit_ff, nxt_dbit;

    // sync reset only exists when built in; otherwise the port is dead
    assign srst_act = SYNC_RST_EN & srst;

    // requests are refused while full, empty or still leaving reset
    assign wr_acc = wr_req & ~full_ff & ~busy_ff;
    assign rd_acc = rd_req & ~empty_ff & ~busy_ff;

    ffc_ecc u_ecc (
        .enc_data (wr_data),
        .inj_sbit (inj_sbit),
        .inj_dbit (inj_dbit),
        .enc_code (enc_code),
        .dec_code (mem_code),
        .dec_data (dec_data),
        .dec_sbit (dec_sbit),
        .dec_dbit (dec_dbit)
    );

    ffc_mem u_mem (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (wr_acc),
        .wr_addr (wptr_ff),
        .wr_code (enc_code),
        .rd_en   (rd_acc),
        .rd_addr (rptr_ff),
        .rd_code (mem_code)
    );

    // thresholds follow the ports while busy, so new values apply from reset on
    always_comb begin
        nxt_pfa = busy_ff ? pf_thr_assert : pfa_ff;
        nxt_pfn = busy_ff ? pf_thr_negate : pfn_ff;
        nxt_pea = busy_ff ? pe_thr_assert : pea_ff;
        nxt_pen = busy_ff ? pe_thr_negate : pen_ff;
        if (srst_act) begin
            nxt_pfa = pf_thr_assert;
            nxt_pfn = pf_thr_negate;
            nxt_pea = pe_thr_assert;
            nxt_pen = pe_thr_negate;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pfa_ff <= FFC_PF_ASSERT_RST;
            pfn_ff <= FFC_PF_NEGATE_RST;
            pea_ff <= FFC_PE_ASSERT_RST;
            pen_ff <= FFC_PE_NEGATE_RST;
        end else begin
            pfa_ff <= nxt_pfa;
            pfn_ff <= nxt_pfn;
            pea_ff <= nxt_pea;
            pen_ff <= nxt_pen;
        end
    end

    // pointers, count and flags; flags are computed from the next count so they never lag
    always_comb begin
        nxt_wptr   = wr_acc ? FFC_PTR_W'(wptr_ff + FFC_PTR_ONE) : wptr_ff;
        nxt_rptr   = rd_acc ? FFC_PTR_W'(rptr_ff + FFC_PTR_ONE) : rptr_ff;
        case ({wr_acc, rd_acc})
            2'b10:   nxt_cnt = FFC_CNT_W'(cnt_ff + FFC_CNT_ONE);
            2'b01:   nxt_cnt = FFC_CNT_W'(cnt_ff - FFC_CNT_ONE);
            default: nxt_cnt = cnt_ff; // both or neither leave the count
        endcase
        nxt_full   = (nxt_cnt == FFC_CNT_FULL);
        nxt_empty  = (nxt_cnt == FFC_CNT_RST);
        nxt_afull  = (nxt_cnt == FFC_CNT_AFULL);
        // hysteresis: hold the flag between the two thresholds
        if (nxt_cnt >= (busy_ff ? pf_thr_assert : pfa_ff)) begin
            nxt_pfull = 1'b1;
        end else if (nxt_cnt < (busy_ff ? pf_thr_negate : pfn_ff)) begin
            nxt_pfull = 1'b0;
        end else begin
            nxt_pfull = pfull_ff;
        end
        if (nxt_cnt <= (busy_ff ? pe_thr_assert : pea_ff)) begin
            nxt_pempty = 1'b1;
        end else if (nxt_cnt > (busy_ff ? pe_thr_negate : pen_ff)) begin
            nxt_pempty = 1'b0;
        end else begin
            nxt_pempty = pempty_ff;
        end
        nxt_busy   = 1'b0;
        nxt_ack    = wr_acc;
        nxt_ovf    = wr_req & full_ff & ~busy_ff;
        nxt_udf    = rd_req & empty_ff & ~busy_ff;
        nxt_rdpend = rd_acc;
        if (srst_act) begin
            nxt_wptr   = FFC_PTR_RST;
            nxt_rptr   = FFC_PTR_RST;
            nxt_cnt    = FFC_CNT_RST;
            nxt_full   = FFC_FULL_RST;
            nxt_empty  = FFC_EMPTY_RST;
            nxt_afull  = FFC_AFULL_RST;
            nxt_pfull  = FFC_PFULL_RST;
            nxt_pempty = FFC_PEMPTY_RST;
            nxt_busy   = FFC_BUSY_RST;
            nxt_ack    = FFC_PULSE_RST;
            nxt_ovf    = FFC_PULSE_RST;
            nxt_udf    = FFC_PULSE_RST;
            nxt_rdpend = FFC_PULSE_RST;
        end
    end

    // every state bit lives on the shared clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wptr_ff   <= FFC_PTR_RST;
            rptr_ff   <= FFC_PTR_RST;
            cnt_ff    <= FFC_CNT_RST;
            full_ff   <= FFC_FULL_RST;
            empty_ff  <= FFC_EMPTY_RST;
            afull_ff  <= FFC_AFULL_RST;
            pfull_ff  <= FFC_PFULL_RST;
            pempty_ff <= FFC_PEMPTY_RST;
            busy_ff   <= FFC_BUSY_RST;
            ack_ff    <= FFC_PULSE_RST;
            ovf_ff    <= FFC_PULSE_RST;
            udf_ff    <= FFC_PULSE_RST;
            rdpend_ff <= FFC_PULSE_RST;
        end else begin
            wptr_ff   <= nxt_wptr;
            rptr_ff   <= nxt_rptr;
            cnt_ff    <= nxt_cnt;
            full_ff   <= nxt_full;
            empty_ff  <= nxt_empty;
            afull_ff  <= nxt_afull;
            pfull_ff  <= nxt_pfull;
            pempty_ff <= nxt_pempty;
            busy_ff   <= nxt_busy;
            ack_ff    <= nxt_ack;
            ovf_ff    <= nxt_ovf;
            udf_ff    <= nxt_udf;
            rdpend_ff <= nxt_rdpend;
        end
    end

    // decoded word lands one cycle after the ram register, costing a cycle but keeping outputs on flops
    always_comb begin
        nxt_dout  = rdpend_ff ? dec_data : dout_ff;
        nxt_valid = rdpend_ff;
        nxt_sbit  = rdpend_ff & dec_sbit;
        nxt_dbit  = rdpend_ff & dec_dbit;
        if (srst_act) begin
            nxt_dout  = FFC_DOUT_RST;
            nxt_valid = FFC_PULSE_RST;
            nxt_sbit  = FFC_PULSE_RST;
            nxt_dbit  = FFC_PULSE_RST;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout_ff  <= FFC_DOUT_RST;
            valid_ff <= FFC_PULSE_RST;
            sbit_ff  <= FFC_PULSE_RST;
            dbit_ff  <= FFC_PULSE_RST;
        end else begin
            dout_ff  <= nxt_dout;
            valid_ff <= nxt_valid;
            sbit_ff  <= nxt_sbit;
            dbit_ff  <= nxt_dbit;
        end
    end

    // outputs straight from flops; the narrow count keeps the top bits
    assign full        = full_ff;
    assign almost_full = afull_ff;
    assign prog_full   = pfull_ff;
    assign wr_ack      = ack_ff;
    assign overflow    = ovf_ff;
    assign underflow   = udf_ff;
    assign empty       = empty_ff;
    assign prog_empty  = pempty_ff;
    assign rd_rst_busy = busy_ff;
    assign rd_data     = dout_ff;
    assign rd_valid    = valid_ff;
    assign sbit_err    = sbit_ff;
    assign dbit_err    = dbit_ff;
    assign data_count  = cnt_ff[FFC_CNT_W-1 -: FFC_DCNT_W];

    // checks on the shared clock
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_write_stores: assert property (
        wr_req && !full_ff && !busy_ff && !srst_act |=> wptr_ff == $past(wptr_ff) + FFC_PTR_ONE && wr_ack)
        else $error("accepted write did not advance write pointer");
    chk_full_blocks: assert property (
        full_ff && !srst_act |=> $stable(wptr_ff) && !wr_ack)
        else $error("write pointer moved while full");
    chk_read_pops: assert property (
        rd_acc && !srst_act ##1 !srst_act |=> rd_valid && rd_data == $past(dec_data))
        else $error("accepted read gave no data two cycles later");
    chk_empty_blocks: assert property (
        empty_ff && !srst_act |=> $stable(rptr_ff) ##1 !rd_valid)
        else $error("read pointer moved while empty");
    chk_both_count: assert property (
        wr_acc && rd_acc && !srst_act |=> $stable(cnt_ff))
        else $error("count changed on write plus read");
    chk_overflow_pulse: assert property (
        overflow |-> $past(wr_req) && $past(full_ff) && !wr_ack)
        else $error("overflow without a refused write");
    chk_underflow_pulse: assert property (
        rd_req && empty_ff && !busy_ff && !srst_act |=> underflow ##1 !rd_valid)
        else $error("refused read gave no underflow");
    chk_ack_cause: assert property (
        wr_ack |-> $past(wr_req) && !overflow)
        else $error("acknowledge without a write request");
    chk_afull_level: assert property (
        almost_full |-> cnt_ff == FFC_CNT_AFULL && !full)
        else $error("almost full at wrong fill level");
    chk_pfull_level: assert property (
        !busy_ff && cnt_ff >= pfa_ff |-> prog_full)
        else $error("programmable full missing above threshold");
    chk_pempty_on: assert property (
        !busy_ff && cnt_ff <= pea_ff |-> prog_empty)
        else $error("programmable empty missing below threshold");
    chk_pempty_off: assert property (
        !busy_ff && cnt_ff > pen_ff |-> !prog_empty)
        else $error("programmable empty stuck above negate threshold");
    chk_busy_drop: assert property (
        rd_rst_busy && !srst_act |=> !rd_rst_busy)
        else $error("reset busy did not drop after reset");
    chk_thr_load: assert property (
        busy_ff |=> pfa_ff == $past(pf_thr_assert) && pen_ff == $past(pe_thr_negate))
        else $error("thresholds not taken up during reset");
    chk_sync_clear: assert property (
        srst_act |=> cnt_ff == FFC_CNT_RST && empty && rd_rst_busy && !rd_valid)
        else $error("synchronous reset did not clear state");
    chk_count_trunc: assert property (
        data_count == cnt_ff[FFC_CNT_W-1:1])
        else $error("narrow count does not keep upper bits");
    chk_err_flags: assert property (
        (sbit_err || dbit_err) |-> rd_valid && !(sbit_err && dbit_err))
        else $error("ecc flag outside a delivered word");
    chk_dbit_cause: assert property (
        rdpend_ff && dec_dbit && !srst_act |=> dbit_err)
        else $error("double error not reported");

endmodule

// *** core/ffc_mem.sv ***
`timescale 1ns/100ps
module ffc_mem import ffc_pkg::*; (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    // write port
    input  wire logic                  wr_en,
    input  wire logic [FFC_PTR_W-1:0]  wr_addr,
    input  wire logic [FFC_CODE_W-1:0] wr_code,
    // read port, data registered
    input  wire logic                  rd_en,
    input  wire logic [FFC_PTR_W-1:0]  rd_addr,
    output logic      [FFC_CODE_W-1:0] rd_code
);

    logic [FFC_CODE_W-1:0] store [FFC_DEPTH];
    logic [FFC_CODE_W-1:0] rd_code_ff;
    logic [FFC_CODE_W-1:0] nxt_rd_code;

    // array has no reset so it maps onto plain ram
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_code;
        end
    end

    // read register only moves on a read, a write to the same slot is not forwarded
    always_comb begin
        nxt_rd_code = rd_en ? store[rd_addr] : rd_code_ff;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_code_ff <= FFC_CODE_RST;
        end else begin
            rd_code_ff <= nxt_rd_code;
        end
    end

    assign rd_code = rd_code_ff;

endmodule

// *** inc/ffc_pkg.sv ***
package ffc_pkg;

    // storage geometry, fixed at build time
    localparam int FFC_DATA_W = 8;
    localparam int FFC_DEPTH  = 16;
    localparam int FFC_PTR_W  = 4;
    localparam int FFC_CNT_W  = 5;   // holds 0 .. FFC_DEPTH
    localparam int FFC_DCNT_W = 4;   // published count width, narrower than the full count

    // single-error-correct, double-error-detect code: 8 data, 4 check, 1 overall parity
    localparam int FFC_PAR_N  = 4;
    localparam int FFC_CODE_W = 13;
    localparam int FFC_DPOS [FFC_DATA_W] = '{3, 5, 6, 7, 9, 10, 11, 12};
    localparam int FFC_INJ_POS_A = 3;  // data bit 0 sits here
    localparam int FFC_INJ_POS_B = 5;  // data bit 1 sits here

    // count and pointer constants
    localparam logic [FFC_CNT_W-1:0] FFC_CNT_RST   = 5'h00;
    localparam logic [FFC_CNT_W-1:0] FFC_CNT_ONE   = 5'h01;
    localparam logic [FFC_CNT_W-1:0] FFC_CNT_FULL  = 5'h10;
    localparam logic [FFC_CNT_W-1:0] FFC_CNT_AFULL = 5'h0F;
    localparam logic [FFC_PTR_W-1:0] FFC_PTR_RST   = 4'h0;
    localparam logic [FFC_PTR_W-1:0] FFC_PTR_ONE   = 4'h1;

    // threshold values used until the first capture during reset
    localparam logic [FFC_CNT_W-1:0] FFC_PF_ASSERT_RST = 5'h0E;
    localparam logic [FFC_CNT_W-1:0] FFC_PF_NEGATE_RST = 5'h0C;
    localparam logic [FFC_CNT_W-1:0] FFC_PE_ASSERT_RST = 5'h02;
    localparam logic [FFC_CNT_W-1:0] FFC_PE_NEGATE_RST = 5'h04;

    // flag and data values after reset
    localparam logic                  FFC_FULL_RST   = 1'b1;
    localparam logic                  FFC_EMPTY_RST  = 1'b1;
    localparam logic                  FFC_AFULL_RST  = 1'b0;
    localparam logic                  FFC_PFULL_RST  = 1'b0;
    localparam logic                  FFC_PEMPTY_RST = 1'b1;
    localparam logic                  FFC_BUSY_RST   = 1'b1;
    localparam logic                  FFC_PULSE_RST  = 1'b0;
    localparam logic [FFC_DATA_W-1:0] FFC_DOUT_RST   = 8'h00;
    localparam logic [FFC_CODE_W-1:0] FFC_CODE_RST   = 13'h0000;

endpackage

// *** verification/ffc_fifo_tb_top.sv ***
`timescale 1ns/100ps
module ffc_fifo_tb_top import ffc_pkg::*; ;
    logic                  sys_clk = 1'b0;
    logic                  nrst    = 1'b0;
    logic                  srst    = 1'b0;
    logic                  wr_req, rd_req, inj_sbit, inj_dbit;
    logic [FFC_DATA_W-1:0] wr_data, rd_data;
    logic                  full, almost_full, prog_full, wr_ack, overflow, rd_valid;
    logic                  empty, prog_empty, underflow, sbit_err, dbit_err, rd_rst_busy;
    logic [FFC_DCNT_W-1:0] data_count;
    // thresholds differ from the built-in defaults so their capture shows
    logic [FFC_CNT_W-1:0]  pf_thr_assert = 5'h0D;
    logic [FFC_CNT_W-1:0]  pf_thr_negate = 5'h0B;
    logic [FFC_CNT_W-1:0]  pe_thr_assert = 5'h03;
    logic [FFC_CNT_W-1:0]  pe_thr_negate = 5'h05;
    // reference model state
    logic [FFC_CNT_W-1:0]  cnt;
    logic                  pf_m, pe_m;
    logic [9:0]            q[$];
    int                    err_total = 0;
    int                    n_tests   = 0;

    always #12.5 sys_clk = ~sys_clk;

    ffc_fifo dut (.sys_clk, .nrst, .srst, .wr_req, .wr_data, .inj_sbit, .inj_dbit, .full, .almost_full,
        .prog_full, .wr_ack, .overflow, .rd_req, .rd_data, .rd_valid, .empty, .prog_empty, .underflow,
        .sbit_err, .dbit_err, .rd_rst_busy, .data_count, .pf_thr_assert, .pf_thr_negate, .pe_thr_assert,
        .pe_thr_negate);

    ffc_partner prt (.sys_clk, .wr_req, .wr_data, .inj_sbit, .inj_dbit, .rd_req);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic model_reset;
        cnt = FFC_CNT_RST;
        q.delete();
        pf_m = 1'b0;
        pe_m = 1'b1;
    endtask

    // one request, then flags compared; a delivered word is checked one edge after the taking edge
    task automatic step(input logic w, r, input logic [7:0] d, input logic si = 1'b0, di = 1'b0);
        logic       wa, ra;
        logic [9:0] e;
        wa = w && (cnt != FFC_CNT_FULL);
        ra = r && (cnt != FFC_CNT_RST);
        prt.op(w, r, d, si, di);
        if (wa) q.push_back({di, si && !di, d});
        cnt = cnt + wa - ra;
        pf_m = (cnt >= pf_thr_assert) ? 1'b1 : (cnt < pf_thr_negate) ? 1'b0 : pf_m;
        pe_m = (cnt <= pe_thr_assert) ? 1'b1 : (cnt > pe_thr_negate) ? 1'b0 : pe_m;
        chk({wr_ack, overflow, underflow}, {wa, w && !wa, r && !ra});
        chk({full, almost_full, empty, data_count},
            {cnt == FFC_CNT_FULL, cnt == FFC_CNT_AFULL, cnt == FFC_CNT_RST, cnt[4:1]});
        chk({prog_full, prog_empty}, {pf_m, pe_m});
        if (ra) begin
            e = q.pop_front();
            @(negedge sys_clk);
            chk({rd_valid, dbit_err, sbit_err}, {1'b1, e[9:8]});
            // an uncorrectable word carries no promise about its data
            if (!e[9]) chk(rd_data, e[7:0]);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, err_total);
    endtask

    task automatic close_out;
        $display("checks made %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under ten microseconds
    initial begin
        #60000;
        err_total++;
        close_out;
    end

    initial begin
        model_reset;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({rd_rst_busy, full, empty}, 3'h7);
        @(posedge sys_clk) nrst <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({rd_rst_busy, full}, 2'h0);
        done("reset");
        // fill past the top, with one single and one double error stored
        for (int i = 0; i < 17; i++) step(1'b1, 1'b0, 8'(i * 13), i == 2, i == 3);
        done("fill");
        // drain past the bottom
        for (int i = 0; i < 17; i++) step(1'b0, 1'b1, 8'h00);
        done("drain");
        step(1'b1, 1'b0, 8'h3C);
        step(1'b1, 1'b1, 8'hC3);
        step(1'b1, 1'b1, 8'h5A);
        done("same edge");
        @(posedge sys_clk) srst <= 1'b1;
        @(posedge sys_clk) srst <= 1'b0;
        @(negedge sys_clk);
        model_reset;
        chk({empty, rd_rst_busy, data_count}, {2'h3, 4'h0});
        step(1'b1, 1'b0, 8'h81);
        done("sync reset");
        // asynchronous reset lands mid-cycle on purpose, clearing with no edge
        #5 nrst <= 1'b0;
        #1 chk({empty, rd_rst_busy, data_count}, {2'h3, 4'h0});
        model_reset;
        // empty thresholds move only while held in reset, so one word must now clear the flag
        pe_thr_assert <= 5'h00;
        pe_thr_negate <= 5'h00;
        @(posedge sys_clk) nrst <= 1'b1;
        step(1'b1, 1'b0, 8'h42);
        step(1'b0, 1'b1, 8'h00);
        done("async reset");
        close_out;
    end
endmodule

// *** verification/ffc_partner.sv ***
`timescale 1ns/100ps
module ffc_partner import ffc_pkg::*; (
    // shared clock
    input  wire logic                  sys_clk,
    // producer side
    output logic                       wr_req   = 1'b0,
    output logic      [FFC_DATA_W-1:0] wr_data  = 8'h00,
    output logic                       inj_sbit = 1'b0,
    output logic                       inj_dbit = 1'b0,
    // consumer side
    output logic                       rd_req   = 1'b0
);
    // one request for one edge, launched just after an edge and held to the taking edge
    task automatic op(input logic w, r, input logic [FFC_DATA_W-1:0] d, input logic si, di);
        @(posedge sys_clk);
        wr_req   <= w;
        rd_req   <= r;
        wr_data  <= d;
        inj_sbit <= si;
        inj_dbit <= di;
        @(posedge sys_clk);
        wr_req   <= 1'b0;
        rd_req   <= 1'b0;
        inj_sbit <= 1'b0;
        inj_dbit <= 1'b0;
        wr_data  <= ~d;  // stale word never lingers on the bus
        @(negedge sys_clk);
    endtask
endmodule
